// ==== common/dual_serial_pkg.sv ====
// Types shared by the dual serial pin and interrupt block.
// Assumes the constants header is included by the user of this package.
package dual_serial_pkg;
  typedef struct packed {
    logic cts_en;
    logic rts_tx;
    logic rts_rx;
    logic loop;
    logic rx_en;
    logic tx_en;
  } chan_mode_t;
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_START = 2'b01,
    S_DATA  = 2'b11,
    S_STOP  = 2'b10
  } ser_state_t;
  typedef enum logic [1:0] {
    ACK_NONE   = 2'b00,
    ACK_TIMER  = 2'b01,
    ACK_SERIAL = 2'b11,
    ACK_EXT    = 2'b10
  } ack_src_t;
endpackage : dual_serial_pkg

// ==== common/dual_serial_regs.svh ====
// Register indices, bit positions, reset values and timing for the
// dual serial pin and interrupt block. Definitions only.
`ifndef DUAL_SERIAL_REGS_SVH
`define DUAL_SERIAL_REGS_SVH
// Word index = byte address / 4
`define REG_MODE_A   4'h0
`define REG_MODE_B   4'h1
`define REG_CSEL     4'h2
`define REG_DATA_A   4'h3
`define REG_DATA_B   4'h4
`define REG_ISR      4'h5
`define REG_IMR      4'h6
`define REG_OPR      4'h7
`define REG_IPR      4'h8
`define REG_ICR      4'h9
`define REG_TMR      4'hA
// Interrupt status layout, per channel stride
`define ISR_STRIDE   4
`define ISR_TXRDY    0
`define ISR_RXRDY    1
`define ISR_CTS      2
`define ISR_TIMER    3
// Interrupt control fields
`define ICR_TEN      0
`define ICR_LVL_LSB  1
`define ICR_RST      8'h00
`define TMR_RST      16'hFFFF
`define MODE_RST     6'h00
`define CSEL_RST     8'h55
// Reference clock and oversampling
`define REF_HZ       3686400
`define OVERSAMPLE   16
`define LAST_SUB     4'hF
`define HALF_SUB     4'h7
`define LAST_BIT     3'h7
`define IRQ7         3'h7
// 16x divisors of the reference clock
`define DIV_50       13'h1200
`define DIV_300      13'h0300
`define DIV_1200     13'h00C0
`define DIV_2400     13'h0060
`define DIV_4800     13'h0030
`define DIV_9600     13'h0018
`define DIV_19200    13'h000C
`define DIV_38400    13'h0006
// Pin synchroniser bit positions
`define PIN_REF      0
`define PIN_RX       1
`define PIN_CTS      3
`define PIN_EXT7     5
`define PIN_W        6
`endif

// ==== core/dual_serial_irq_and_pins.sv ====
// Two serial channels with pins, baud selection, timer and interrupts.
// Assumes an Avalon-MM master on sys_clk_i and a reference clock pin.
`timescale 1ns/1ps
`include "dual_serial_regs.svh"

module dual_serial_irq_and_pins
  import dual_serial_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        reference_clock_in_i,
  input  wire logic        chan_a_serial_in_i,
  input  wire logic        chan_b_serial_in_i,
  input  wire logic        chan_a_clear_to_send_n_i,
  input  wire logic        chan_b_clear_to_send_n_i,
  input  wire logic        ext_irq7_n_i,
  input  wire logic        iack_i,
  input  wire logic [2:0]  iack_level_i,
  output logic             chan_a_serial_out_o,
  output logic             chan_b_serial_out_o,
  output logic             chan_a_request_to_send_n_o,
  output logic             chan_b_request_to_send_n_o,
  output logic             serial_irq_n_o,
  output logic             timer_interrupt_request_n_o,
  output logic [2:0]       serial_irq_level_o,
  output ack_src_t         ack_source_o
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  wire  [`PIN_W-1:0] pin_raw = {ext_irq7_n_i,
    chan_b_clear_to_send_n_i, chan_a_clear_to_send_n_i,
    chan_b_serial_in_i, chan_a_serial_in_i,
    reference_clock_in_i};
  logic [`PIN_W-1:0] pin_s1_q;
  logic [`PIN_W-1:0] pin_s2_q;
  logic [`PIN_W-1:0] pin_s3_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Rising edge of the reference clock; 3.6864 MHz is well below
  // half of sys_clk, so no edge is missed
  wire ref_tick = pin_s2_q[`PIN_REF] & ~pin_s3_q[`PIN_REF];

  // ************************************************************
  // Register bus
  // ************************************************************
  logic        wait_q;
  logic [31:0] rdata_q;
  chan_mode_t  mode_q [2];
  logic [7:0]  csel_q;
  logic [7:0]  isr_q;
  logic [7:0]  imr_q;
  logic [7:0]  opr_q;
  logic [7:0]  icr_q;
  logic [15:0] tmr_pre_q;
  logic [15:0] tmr_q;
  logic [7:0]  rx_data [2];
  logic [2:0]  ev [2];
  logic        tx_wr [2];
  logic        rx_rd [2];

  wire       req    = avs_read_i | avs_write_i;
  wire       acc    = req & ~wait_q;
  wire       wr_acc = acc & avs_write_i;
  wire       rd_acc = acc & avs_read_i;
  wire [3:0] idx    = avs_address_i[5:2];
  wire [7:0] wdat   = avs_writedata_i[7:0];

  assign tx_wr[0] = wr_acc & (idx == `REG_DATA_A);
  assign tx_wr[1] = wr_acc & (idx == `REG_DATA_B);
  assign rx_rd[0] = rd_acc & (idx == `REG_DATA_A);
  assign rx_rd[1] = rd_acc & (idx == `REG_DATA_B);
  wire isr_rd = rd_acc & (idx == `REG_ISR);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `REG_MODE_A: rd_mux[5:0] = mode_q[0];
      `REG_MODE_B: rd_mux[5:0] = mode_q[1];
      `REG_CSEL:   rd_mux[7:0] = csel_q;
      `REG_DATA_A: rd_mux[7:0] = rx_data[0];
      `REG_DATA_B: rd_mux[7:0] = rx_data[1];
      `REG_ISR:    rd_mux[7:0] = isr_q;
      `REG_IMR:    rd_mux[7:0] = imr_q;
      `REG_OPR:    rd_mux[7:0] = opr_q;
      `REG_IPR:    rd_mux[1:0] = ~pin_s2_q[`PIN_CTS +: 2];
      `REG_ICR:    rd_mux[7:0] = icr_q;
      `REG_TMR:    rd_mux[15:0] = tmr_q;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait cycle: read data is latched while waitrequest is high
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q)
        rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q[0] <= `MODE_RST;
      mode_q[1] <= `MODE_RST;
      csel_q    <= `CSEL_RST;
      imr_q     <= 8'h00;
      opr_q     <= 8'h00;
      icr_q     <= `ICR_RST;
      tmr_pre_q <= `TMR_RST;
    end else if (wr_acc) begin
      case (idx)
        `REG_MODE_A: mode_q[0] <= chan_mode_t'(wdat[5:0]);
        `REG_MODE_B: mode_q[1] <= chan_mode_t'(wdat[5:0]);
        `REG_CSEL:   csel_q    <= wdat;
        `REG_IMR:    imr_q     <= wdat;
        `REG_OPR:    opr_q     <= wdat;
        `REG_ICR:    icr_q     <= wdat;
        `REG_TMR:    tmr_pre_q <= avs_writedata_i[15:0];
        default:     ;
      endcase
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  // ************************************************************
  // Counter/timer
  // ************************************************************
  wire tmr_ev = ref_tick & (tmr_q == 16'h0000);
  // Preset write restarts the count, else a long count must run out first
  wire tmr_wr = wr_acc & (idx == `REG_TMR);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      tmr_q <= `TMR_RST;
    else if (tmr_wr)
      tmr_q <= avs_writedata_i[15:0];
    else if (ref_tick)
      tmr_q <= tmr_ev ? tmr_pre_q : tmr_q - 16'h0001;
  end

  // ************************************************************
  // Baud divisor table
  // ************************************************************
  // Each divisor gives a 16x tick of the nominal rate
  function automatic logic [12:0] baud_div(input logic [2:0] s);
    case (s)
      3'h0:    baud_div = `DIV_50;
      3'h1:    baud_div = `DIV_300;
      3'h2:    baud_div = `DIV_1200;
      3'h3:    baud_div = `DIV_2400;
      3'h4:    baud_div = `DIV_4800;
      3'h5:    baud_div = `DIV_9600;
      3'h6:    baud_div = `DIV_19200;
      default: baud_div = `DIV_38400;
    endcase
  endfunction : baud_div

  // ************************************************************
  // Channels
  // ************************************************************
  logic ser_out_q [2];
  logic rts_n_q   [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    chan_mode_t m;
    logic [12:0] div_q;
    ser_state_t  tx_st;
    ser_state_t  rx_st;
    logic [3:0]  tx_sub;
    logic [3:0]  rx_sub;
    logic [2:0]  tx_bit;
    logic [2:0]  rx_bit;
    logic [7:0]  tx_sh;
    logic [7:0]  tx_hold;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_dat_q;
    logic        tx_full;
    logic        rx_full;
    logic        tx_line;

    assign m = mode_q[c];
    // Independent clock select nibble per channel
    wire [12:0] div_max = baud_div(csel_q[c*4 +: 3]);
    wire        tick    = ref_tick & (div_q == 13'h0000);
    // Bit boundary ends the 16-tick cell: the falling side
    wire        tx_go   = tick & (tx_sub == `LAST_SUB);
    wire        cts_n   = pin_s2_q[`PIN_CTS + c];
    wire        cts_ok  = ~m.cts_en | ~cts_n;
    wire        tx_load = tx_go & (tx_st == S_IDLE) & tx_full
                          & m.tx_en & cts_ok;
    wire        rx_in   = m.loop ? tx_line : pin_s2_q[`PIN_RX + c];
    wire        rx_done = tick & (rx_st == S_STOP)
                          & (rx_sub == `LAST_SUB);
    wire        tx_busy = (tx_st != S_IDLE);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
        div_q <= 13'h0000;
      else if (ref_tick)
        div_q <= (div_q == 13'h0000) ? div_max - 13'h0001
                                     : div_q - 13'h0001;
    end

    // Transmitter
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        tx_st   <= S_IDLE;
        tx_sub  <= 4'h0;
        tx_bit  <= 3'h0;
        tx_sh   <= 8'h00;
        tx_hold <= 8'h00;
        tx_full <= 1'b0;
        tx_line <= 1'b1;
      end else begin
        if (tick)
          tx_sub <= tx_sub + 4'h1;
        case (tx_st)
          S_IDLE: begin
            tx_line <= 1'b1;
            if (tx_load) begin
              tx_sh   <= tx_hold;
              tx_full <= 1'b0;
              tx_line <= 1'b0;
              tx_st   <= S_START;
            end
          end
          S_START: begin
            if (tx_go) begin
              tx_line <= tx_sh[0];
              tx_sh   <= tx_sh >> 1;
              tx_bit  <= 3'h0;
              tx_st   <= S_DATA;
            end
          end
          S_DATA: begin
            if (tx_go) begin
              if (tx_bit == `LAST_BIT) begin
                tx_line <= 1'b1;
                tx_st   <= S_STOP;
              end else begin
                tx_line <= tx_sh[0];
                tx_sh   <= tx_sh >> 1;
                tx_bit  <= tx_bit + 3'h1;
              end
            end
          end
          S_STOP: begin
            if (tx_go)
              tx_st <= S_IDLE;
          end
          default: tx_st <= S_IDLE;
        endcase
        // A write overrides the hand-off in the same cycle
        if (tx_wr[c]) begin
          tx_hold <= wdat;
          tx_full <= 1'b1;
        end
      end
    end

    // Receiver
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        rx_st    <= S_IDLE;
        rx_sub   <= 4'h0;
        rx_bit   <= 3'h0;
        rx_sh    <= 8'h00;
        rx_dat_q <= 8'h00;
        rx_full  <= 1'b0;
      end else begin
        if (rx_rd[c])
          rx_full <= 1'b0;
        if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          case (rx_st)
            S_IDLE: begin
              rx_sub <= 4'h0;
              if (m.rx_en & ~rx_in)
                rx_st <= S_START;
            end
            S_START: begin
              // Mid start bit recheck rejects glitches
              if (rx_sub == `HALF_SUB) begin
                rx_sub <= 4'h0;
                rx_bit <= 3'h0;
                rx_st  <= rx_in ? S_IDLE : S_DATA;
              end
            end
            S_DATA: begin
              if (rx_sub == `LAST_SUB) begin
                rx_sh  <= {rx_in, rx_sh[7:1]};
                rx_bit <= rx_bit + 3'h1;
                if (rx_bit == `LAST_BIT)
                  rx_st <= S_STOP;
              end
            end
            S_STOP: begin
              if (rx_sub == `LAST_SUB) begin
                rx_dat_q <= rx_sh;
                rx_full  <= 1'b1;
                rx_st    <= S_IDLE;
              end
            end
            default: rx_st <= S_IDLE;
          endcase
        end
      end
    end

    assign rx_data[c] = rx_dat_q;
    assign ev[c] = {pin_s2_q[`PIN_CTS + c] ^ pin_s3_q[`PIN_CTS + c],
                    rx_done, tx_load};

    // Pin drivers
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        ser_out_q[c] <= 1'b1;
        rts_n_q[c]   <= 1'b1;
      end else begin
        ser_out_q[c] <= m.loop | tx_line;
        if (m.rts_tx)
          rts_n_q[c] <= ~(tx_busy | tx_full);
        else if (m.rts_rx)
          rts_n_q[c] <= rx_full;
        else
          rts_n_q[c] <= ~opr_q[c];
      end
    end
  end

  assign chan_a_serial_out_o        = ser_out_q[0];
  assign chan_b_serial_out_o        = ser_out_q[1];
  assign chan_a_request_to_send_n_o = rts_n_q[0];
  assign chan_b_request_to_send_n_o = rts_n_q[1];

  // ************************************************************
  // Interrupt status and outputs
  // ************************************************************
  logic [7:0] isr_set;
  always_comb begin
    isr_set = 8'h00;
    isr_set[`ISR_TXRDY]              = ev[0][0];
    isr_set[`ISR_RXRDY]              = ev[0][1];
    isr_set[`ISR_CTS]                = ev[0][2];
    isr_set[`ISR_TIMER]              = tmr_ev;
    isr_set[`ISR_STRIDE + `ISR_TXRDY] = ev[1][0];
    isr_set[`ISR_STRIDE + `ISR_RXRDY] = ev[1][1];
    isr_set[`ISR_STRIDE + `ISR_CTS]   = ev[1][2];
  end

  // Set wins over the read clear; only bits the read reported are cleared
  wire [7:0] isr_d  = (isr_rd ? (isr_q & ~rdata_q[7:0]) : isr_q) | isr_set;
  wire       ser_on = |(isr_d & imr_q);
  // Software should mask the timer bit in the serial mask
  wire       tmr_on = isr_d[`ISR_TIMER] & icr_q[`ICR_TEN];
  wire [2:0] lvl    = icr_q[`ICR_LVL_LSB +: 3];
  wire       ext7   = ~pin_s2_q[`PIN_EXT7];
  logic      tmr_on_q;
  wire       srv_t  = tmr_on_q & (iack_level_i == `IRQ7);
  wire       srv_s  = ~serial_irq_n_o & (iack_level_i == serial_irq_level_o);
  wire       srv_e  = ext7 & (iack_level_i == `IRQ7);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      isr_q                       <= 8'h00;
      serial_irq_n_o              <= 1'b1;
      tmr_on_q                    <= 1'b0;
      timer_interrupt_request_n_o <= 1'b1;
      serial_irq_level_o          <= 3'h0;
      ack_source_o                <= ACK_NONE;
    end else begin
      isr_q                       <= isr_d;
      serial_irq_n_o              <= ~ser_on;
      tmr_on_q                    <= tmr_on;
      timer_interrupt_request_n_o <= ~tmr_on;
      serial_irq_level_o          <= lvl;
      if (iack_i) begin
        if (srv_t)
          ack_source_o <= ACK_TIMER;
        else if (srv_s)
          ack_source_o <= ACK_SERIAL;
        else if (srv_e)
          ack_source_o <= ACK_EXT;
        else
          ack_source_o <= ACK_NONE;
      end
    end
  end

endmodule : dual_serial_irq_and_pins

// ==== tb/dual_serial_irq_and_pins_chk.sv ====
// Port checker for the dual serial pin and interrupt block.
// Assumes one clock domain with an async active-low reset.
`timescale 1ns/1ps
module dual_serial_irq_and_pins_chk
  import dual_serial_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        ext_irq7_n_i,
  input wire logic        iack_i,
  input wire logic [2:0]  iack_level_i,
  input wire logic        chan_a_serial_out_o,
  input wire logic        chan_b_serial_out_o,
  input wire logic        serial_irq_n_o,
  input wire logic        timer_interrupt_request_n_o,
  input wire logic [2:0]  serial_irq_level_o,
  input wire ack_src_t    ack_source_o
);
  default clocking dck @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ********
  // Bus
  // ********
  property p_accept; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_accept: assert property (p_accept) else $error("request not answered");
  property p_one_low; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_one_low: assert property (p_one_low) else $error("wait low too long");
  property p_idle; !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_upper; avs_readdata_o[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  // ********
  // Acknowledge order and serial lines
  // ********
  property p_ack_hold; !iack_i |=> $stable(ack_source_o); endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack source moved");
  property p_ack_timer; iack_i && iack_level_i == 3'h7 && !timer_interrupt_request_n_o |=> ack_source_o == ACK_TIMER;
  endproperty
  a_ack_timer: assert property (p_ack_timer) else $error("timer not first");
  property p_ack_serial; iack_i && !serial_irq_n_o && timer_interrupt_request_n_o &&
    iack_level_i == serial_irq_level_o |=> ack_source_o == ACK_SERIAL; endproperty
  a_ack_serial: assert property (p_ack_serial) else $error("serial not served");
  property p_ack_none; iack_i && iack_level_i != 3'h7 && serial_irq_n_o |=> ack_source_o == ACK_NONE; endproperty
  a_ack_none: assert property (p_ack_none) else $error("spurious ack source");
  property p_ack_ext; (!ext_irq7_n_i)[*4] ##0 (iack_i && iack_level_i == 3'h7 && serial_irq_n_o &&
    timer_interrupt_request_n_o) |=> ack_source_o == ACK_EXT; endproperty
  a_ack_ext: assert property (p_ack_ext) else $error("external not served");
  property p_txa_hold; $changed(chan_a_serial_out_o) |=> $stable(chan_a_serial_out_o)[*8]; endproperty
  a_txa_hold: assert property (p_txa_hold) else $error("line A glitch");
  property p_txb_hold; $changed(chan_b_serial_out_o) |=> $stable(chan_b_serial_out_o)[*8]; endproperty
  a_txb_hold: assert property (p_txb_hold) else $error("line B glitch");
endmodule : dual_serial_irq_and_pins_chk

bind dual_serial_irq_and_pins dual_serial_irq_and_pins_chk dual_serial_irq_and_pins_chk_inst (
  .sys_clk_i, .rst_b_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .ext_irq7_n_i,
  .iack_i, .iack_level_i, .chan_a_serial_out_o, .chan_b_serial_out_o, .serial_irq_n_o,
  .timer_interrupt_request_n_o, .serial_irq_level_o, .ack_source_o);

// ==== tb/serial_far_end.sv ====
// Far end: reference oscillator and remote serial devices.
// Assumes lines idle high through pull-ups when nothing sends.
`timescale 1ns/1ps
module serial_far_end (
  output logic      ref_clk_o,
  output logic      line_a_o,
  output logic      line_b_o,
  input  wire logic tx_a_i,
  input  wire logic tx_b_i
);
  initial ref_clk_o = 1'b0;
  initial line_a_o = 1'b1;
  initial line_b_o = 1'b1;
  always #135.634 ref_clk_o = ~ref_clk_o;
  task automatic send_a(input logic [7:0] b, input real bit_ns);
    line_a_o = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      line_a_o = b[i];
      #(bit_ns);
    end
    line_a_o = 1'b1;
    #(bit_ns);
  endtask : send_a
  // Bit time taken from the start bit, so the first data bit must be 1
  task automatic catch_tx(input logic sel, output logic [7:0] b, output real bit_ns);
    real t0;
    if (sel) @(negedge tx_b_i); else @(negedge tx_a_i);
    t0 = $realtime;
    if (sel) @(posedge tx_b_i); else @(posedge tx_a_i);
    bit_ns = $realtime - t0;
    #(bit_ns / 2.0);
    for (int i = 0; i < 8; i++) begin
      b[i] = sel ? tx_b_i : tx_a_i;
      #(bit_ns);
    end
  endtask : catch_tx
endmodule : serial_far_end

// ==== tb/test_dual_serial_irq_and_pins.sv ====
// Self-checking bench for the dual serial pin and interrupt block.
// Assumes the far-end model drives reference clock and receive lines.
`timescale 1ns/1ps
`include "dual_serial_regs.svh"
module test_dual_serial_irq_and_pins
  import dual_serial_pkg::*;
;
  localparam real REF_NS = 271.267;
  logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, iack = 1'b0;
  logic        cts_a_n = 1'b1, cts_b_n = 1'b1, ext_n = 1'b1;
  logic [5:0]  addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [2:0]  lvl = 3'h0, irq_lvl;
  logic        wreq, ref_clk, rx_a, rx_b, tx_a, tx_b, rts_a_n, rts_b_n, irq_n, timer_interrupt_request_n_n;
  logic [7:0]  got;
  ack_src_t    ack;
  real         bit_ns;
  int          fail_count = 0, num_checks = 0;
  always #25 clk = ~clk;
  dual_serial_irq_and_pins dual_serial_irq_and_pins_inst (
    .sys_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .reference_clock_in_i(ref_clk), .chan_a_serial_in_i(rx_a), .chan_b_serial_in_i(rx_b),
    .chan_a_clear_to_send_n_i(cts_a_n), .chan_b_clear_to_send_n_i(cts_b_n), .ext_irq7_n_i(ext_n),
    .iack_i(iack), .iack_level_i(lvl), .chan_a_serial_out_o(tx_a), .chan_b_serial_out_o(tx_b),
    .chan_a_request_to_send_n_o(rts_a_n), .chan_b_request_to_send_n_o(rts_b_n), .serial_irq_n_o(irq_n),
    .timer_interrupt_request_n_o(timer_interrupt_request_n_n), .serial_irq_level_o(irq_lvl), .ack_source_o(ack));
  serial_far_end serial_far_end_inst (
    .ref_clk_o(ref_clk), .line_a_o(rx_a), .line_b_o(rx_b), .tx_a_i(tx_a), .tx_b_i(tx_b));
  // ********
  // Shared tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(negedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) chk(wreq, 32'h0);
    @(posedge clk);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic ack_chk(input logic [2:0] l, input ack_src_t e);
    @(posedge clk);
    iack <= 1'b1;
    lvl <= l;
    @(posedge clk);
    iack <= 1'b0;
    @(negedge clk);
    chk(ack, e);
  endtask : ack_chk
  function automatic logic near(input real a, input real e);
    return (a > e - 150.0) && (a < e + 150.0);
  endfunction : near
  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    chk({tx_a, tx_b, rts_a_n, rts_b_n, irq_n, timer_interrupt_request_n_n}, 32'h3F);
    bus(0, `REG_CSEL, 0, q);
    chk(q, 32'h55);
    bus(1, 4'hF, 32'hFF, q);
    bus(0, 4'hF, 0, q);
    chk(q, 32'h0);
  endtask : t_reset
  task automatic t_port;
    bus(1, `REG_OPR, 32'h1, q);
    repeat (2) @(negedge clk);
    chk({rts_a_n, rts_b_n}, 32'h1);
    bus(1, `REG_OPR, 32'h2, q);
    repeat (2) @(negedge clk);
    chk({rts_a_n, rts_b_n}, 32'h2);
    bus(1, `REG_OPR, 32'h0, q);
  endtask : t_port
  task automatic t_tx;
    bus(1, `REG_CSEL, 32'h67, q);
    bus(1, `REG_MODE_A, 32'h1, q);
    bus(1, `REG_MODE_B, 32'h1, q);
    fork
      serial_far_end_inst.catch_tx(1'b0, got, bit_ns);
      bus(1, `REG_DATA_A, 32'hA5, q);
    join
    chk(got, 32'hA5);
    chk(near(bit_ns, `OVERSAMPLE * `DIV_38400 * REF_NS), 32'h1);
    fork
      serial_far_end_inst.catch_tx(1'b1, got, bit_ns);
      bus(1, `REG_DATA_B, 32'h3B, q);
    join
    chk(got, 32'h3B);
    chk(near(bit_ns, `OVERSAMPLE * `DIV_19200 * REF_NS), 32'h1);
  endtask : t_tx
  task automatic t_rx;
    bus(1, `REG_MODE_A, 32'h2, q);
    bus(1, `REG_IMR, 32'h2, q);
    serial_far_end_inst.send_a(8'h96, `OVERSAMPLE * `DIV_38400 * REF_NS);
    for (int n = 0; n < 3000 && irq_n !== 1'b0; n++) @(negedge clk);
    chk(irq_n, 32'h0);
    bus(0, `REG_DATA_A, 0, q);
    chk(q, 32'h96);
    bus(0, `REG_ISR, 0, q);
    chk(q[1], 32'h1);
    repeat (2) @(negedge clk);
    chk(irq_n, 32'h1);
    bus(1, `REG_IMR, 32'h0, q);
  endtask : t_rx
  task automatic t_cts;
    bus(0, `REG_ISR, 0, q);
    cts_a_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk(irq_n, 32'h1);
    bus(0, `REG_IPR, 0, q);
    chk(q[1:0], 32'h1);
    bus(0, `REG_ISR, 0, q);
    chk(q[2], 32'h1);
    bus(1, `REG_IMR, 32'h40, q);
    cts_b_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk(irq_n, 32'h0);
    bus(0, `REG_ISR, 0, q);
    repeat (2) @(negedge clk);
    chk(irq_n, 32'h1);
  endtask : t_cts
  task automatic t_loop;
    int lows;
    lows = 0;
    bus(1, `REG_MODE_A, 32'h5, q);
    bus(1, `REG_DATA_A, 32'h00, q);
    repeat (6000) begin
      @(negedge clk);
      if (tx_a !== 1'b1) lows++;
    end
    chk(lows, 32'h0);
    bus(1, `REG_MODE_A, 32'hA, q);
    repeat (2) @(negedge clk);
    chk(rts_a_n, 32'h0);
    bus(1, `REG_MODE_A, 32'h11, q);
    bus(1, `REG_DATA_A, 32'h55, q);
    repeat (2) @(negedge clk);
    chk(rts_a_n, 32'h0);
    repeat (6000) @(negedge clk);
    chk(rts_a_n, 32'h1);
  endtask : t_loop
  task automatic t_irq_order;
    bus(1, `REG_IMR, 32'h0, q); // Timer bit stays masked
    bus(1, `REG_TMR, 32'h4, q);
    repeat (100) @(negedge clk);
    chk(timer_interrupt_request_n_n, 32'h1);
    bus(1, `REG_ICR, 32'hF, q);
    repeat (3) @(negedge clk);
    ack_chk(3'h3, ACK_NONE);
    bus(1, `REG_IMR, 32'h4, q);
    cts_a_n <= 1'b1;
    ext_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk({irq_n, timer_interrupt_request_n_n, irq_lvl}, 32'h07);
    ack_chk(3'h7, ACK_TIMER);
    bus(1, `REG_ICR, 32'hE, q);
    repeat (3) @(negedge clk);
    chk(timer_interrupt_request_n_n, 32'h1);
    ack_chk(3'h7, ACK_SERIAL);
    bus(1, `REG_IMR, 32'h0, q);
    repeat (3) @(negedge clk);
    ack_chk(3'h7, ACK_EXT);
    bus(1, `REG_TMR, 32'hFFFF, q);
    ext_n <= 1'b1;
  endtask : t_irq_order
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_port();
    t_tx();
    t_rx();
    t_cts();
    t_loop();
    t_irq_order();
    end_of_test();
  end
  // About 33k cycles expected; allow 90k, close to three times that
  initial begin
    #4500000;
    fail_count++;
    end_of_test();
  end
endmodule : test_dual_serial_irq_and_pins
